// *** design/csc_consts.vh ***
`ifndef CSC_CONSTS_VH
`define CSC_CONSTS_VH

// register map (offset chosen, single register)
`define CSC_ADDR_W 4
`define CSC_OFF_CTRL0 4'h0
`define CSC_CTRL0_RESET 8'h00

// field positions
`define CSC_BIT_ON 7
`define CSC_BIT_RM 6
`define CSC_RNG_HI 3
`define CSC_RNG_LO 2
`define CSC_BIT_DIR 1
`define CSC_BIT_XCS 0

// writable bits mask
`define CSC_WR_MASK 8'hCD

// range codes
`define CSC_RNG_OFF 2'h0
`define CSC_RNG_LOW 2'h1
`define CSC_RNG_MED 2'h2
`define CSC_RNG_HIGH 2'h3

// timer clock source selection codes
`define CSC_TSRC_SYS 2'h0
`define CSC_TSRC_PIN 2'h1
`define CSC_TSRC_OSC 2'h2

`endif

// *** design/csc_control.v ***
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "csc_consts.vh"
// Notes on behaviour
// - bit 7 high turns the sensing module on; low keeps it off.
// - bit 6 high selects variable reference mode; low selects fixed mode.
// - fixed mode range: 00 off, 01 low, 10 medium, 11 high.
// - external timer clock: select bit 1 uses sense oscillator, 0 the pin.
// - without external option timer uses system clock, select bit ignored.
module csc_control (
   // clock and asynchronous reset
   input wire sys_clk,
   input wire reset_n,
   // register port; read data follows the strobe by one cycle
   input wire [`CSC_ADDR_W-1:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   // levels from the analog side and the timer pins, already in this clock domain
   input wire oscillator_direction_status,
   input wire timer_clock_option,
   input wire sense_osc_clk,
   input wire timer_clock_pin,
   // oscillator controls towards the analog side
   output reg sense_module_on,
   output reg reference_mode_select,
   output reg osc_run,
   output reg noise_detect,
   output reg [1:0] current_level,
   // timer clock selection
   output reg [1:0] timer_src_sel,
   output reg timer_ext_clk
);


   // a write lands in ctrl_r on the strobe edge; decoded outputs follow one edge later.
   // everything leaving the block is a flop, so the analog side never sees decode glitches.
   // the cost is one extra cycle of latency between a write and the oscillator controls.

   // writable and reset images of the control register
   localparam [7:0] WR_MASK = `CSC_WR_MASK;
   localparam [7:0] CTRL_RST = `CSC_CTRL0_RESET;
   localparam integer CTRL_W = 8;

   // stored control bits and their next value
   reg [7:0] ctrl_r;
   wire [7:0] ctrl_nxt;

   // sampled oscillator direction level, shown in the read view
   reg dir_r;

   // strobe qualifiers after address decode
   wire hit_wr;
   wire hit_rd;

   // named views of the stored fields
   wire field_on;
   wire field_rm;
   wire [1:0] field_rng;
   wire field_xcs;

   // decoder results, registered before they leave the block
   wire dec_run;
   wire dec_noise;
   wire [1:0] dec_level;

   // read image and the next value of the read data
   wire [7:0] rd_view;
   reg [7:0] rdata_nxt;

   // timer clock selection next values
   reg [1:0] tsrc_nxt;
   reg ext_nxt;

   // bit index shared by the per-bit loops below
   genvar gi;

   // the single register sits at one offset; both strobes share this match
   function csc_hit_ctrl0;
      input [`CSC_ADDR_W-1:0] addr;
      begin
         csc_hit_ctrl0 = (addr == `CSC_OFF_CTRL0);
      end
   endfunction

   // timer source code from the option level and the select bit
   function [1:0] csc_tsrc_code;
      input opt_lvl;
      input sel_bit;
      begin
         if (!opt_lvl) begin
            csc_tsrc_code = `CSC_TSRC_SYS;
         end else if (sel_bit) begin
            csc_tsrc_code = `CSC_TSRC_OSC;
         end else begin
            csc_tsrc_code = `CSC_TSRC_PIN;
         end
      end
   endfunction

   // a write strobe only counts at the mapped offset; others are dropped
   assign hit_wr = reg_wr & csc_hit_ctrl0(reg_addr);
   // a read strobe at any other offset returns zero
   assign hit_rd = reg_rd & csc_hit_ctrl0(reg_addr);

   // next value per bit: writable bits take write data, the rest keep their reset value
   generate
      for (gi = 0; gi < CTRL_W; gi = gi + 1) begin : g_ctrl_bit
         if (WR_MASK[gi]) begin : g_wr
            assign ctrl_nxt[gi] = hit_wr ? reg_wdata[gi] : ctrl_r[gi];
         end else begin : g_fixed
            assign ctrl_nxt[gi] = CTRL_RST[gi];
         end
      end
   endgenerate

   // control register; reset clears every bit
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_r <= CTRL_RST;
      end else begin
         ctrl_r <= ctrl_nxt;
      end
   end

   // field views keep the bit positions in one place
   assign field_on = ctrl_r[`CSC_BIT_ON];
   assign field_rm = ctrl_r[`CSC_BIT_RM];
   assign field_rng = ctrl_r[`CSC_RNG_HI:`CSC_RNG_LO];
   assign field_xcs = ctrl_r[`CSC_BIT_XCS];

   // status level is taken once so a read never sees it move inside a cycle
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         dir_r <= 1'h0;
      end else begin
         dir_r <= oscillator_direction_status;
      end
   end

   // read image per bit: status from the sampled level, unused slots zero, the rest stored
   generate
      for (gi = 0; gi < CTRL_W; gi = gi + 1) begin : g_rd_bit
         if (gi == `CSC_BIT_DIR) begin : g_status
            assign rd_view[gi] = dir_r;
         end else if (WR_MASK[gi]) begin : g_stored
            assign rd_view[gi] = ctrl_r[gi];
         end else begin : g_unused
            assign rd_view[gi] = 1'h0;
         end
      end
   endgenerate

   // idle or unmapped cycles give zero, so several slaves can share an or-ed bus
   always @* begin
      rdata_nxt = 8'h00;
      if (hit_rd) begin
         rdata_nxt = rd_view;
      end
   end

   // read data stands only in the cycle after the strobe
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= rdata_nxt;
      end
   end

   // range decoding lives in its own block so the mode table is easy to audit
   csc_decode csc_decode_inst (
      .module_on(field_on),
      .ref_mode(field_rm),
      .range_code(field_rng),
      .osc_run(dec_run),
      .noise_detect(dec_noise),
      .current_level(dec_level)
   );

   // the chosen level is passed on; the system source carries no external level
   always @* begin
      tsrc_nxt = csc_tsrc_code(timer_clock_option, field_xcs);
      case (tsrc_nxt)
         `CSC_TSRC_PIN: ext_nxt = timer_clock_pin;
         `CSC_TSRC_OSC: ext_nxt = sense_osc_clk;
         default: ext_nxt = 1'h0;
      endcase
   end

   // mode bits leave through flops so they track ctrl_r one cycle behind
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         sense_module_on <= 1'h0;
         reference_mode_select <= 1'h0;
      end else begin
         sense_module_on <= field_on;
         reference_mode_select <= field_rm;
      end
   end

   // oscillator drive leaves through flops; all three change on the same edge
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         osc_run <= 1'h0;
         noise_detect <= 1'h0;
         current_level <= `CSC_RNG_OFF;
      end else begin
         osc_run <= dec_run;
         noise_detect <= dec_noise;
         current_level <= dec_level;
      end
   end

   // timer selection is registered; the external clock is a sampled level one cycle late
   // limitation: a source faster than half the system clock is aliased, not counted
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         timer_src_sel <= `CSC_TSRC_SYS;
         timer_ext_clk <= 1'h0;
      end else begin
         timer_src_sel <= tsrc_nxt;
         timer_ext_clk <= ext_nxt;
      end
   end
endmodule // csc_control

// *** design/csc_decode.v ***
`timescale 1ns/1ps
// turns control fields into oscillator drive settings
module csc_decode (
   input wire module_on,
   input wire ref_mode,
   input wire [1:0] range_code,
   output reg osc_run,
   output reg noise_detect,
   output reg [1:0] current_level
);
`include "csc_consts.vh"

   // range decoding depends on reference mode
   always @* begin
      osc_run = 1'h0;
      noise_detect = 1'h0;
      current_level = `CSC_RNG_OFF;
      if (module_on) begin
         if (range_code == `CSC_RNG_OFF) begin
            osc_run = ref_mode;
            noise_detect = ref_mode;
         end else begin
            osc_run = 1'h1;
            current_level = range_code;
         end
      end
   end
endmodule // csc_decode

// *** tb/csc_control_assertions.sv ***
`timescale 1ns/1ps
// watches the control block ports; decoded outputs land two edges after a write
module csc_chk (
   input wire sys_clk,
   input wire reset_n,
   input wire [3:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_rdata,
   input wire sense_module_on,
   input wire reference_mode_select,
   input wire osc_run,
   input wire noise_detect,
   input wire [1:0] current_level,
   input wire [1:0] timer_src_sel,
   input wire timer_ext_clk
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   // only address zero is mapped, so other writes must not move the outputs
   wire wr0 = reg_wr && reg_addr == 4'h0;
   property p_on; wr0 |-> ##2 sense_module_on == $past(reg_wdata[7], 2); endproperty
   a_on: assert property (p_on) else $error("enable bit not applied");
   property p_rm; wr0 |-> ##2 reference_mode_select == $past(reg_wdata[6], 2); endproperty
   a_rm: assert property (p_rm) else $error("reference mode not applied");
   property p_off; !sense_module_on |-> !osc_run && current_level == 2'h0; endproperty
   a_off: assert property (p_off) else $error("oscillator active while off");
   property p_fix; sense_module_on && !reference_mode_select |-> osc_run == (current_level != 2'h0) && !noise_detect; endproperty
   a_fix: assert property (p_fix) else $error("fixed mode range wrong");
   property p_var; sense_module_on && reference_mode_select |-> osc_run && noise_detect == (current_level == 2'h0); endproperty
   a_var: assert property (p_var) else $error("variable mode range wrong");
   property p_sys; timer_src_sel == 2'h0 |-> !timer_ext_clk; endproperty
   a_sys: assert property (p_sys) else $error("external clock on system source");
   property p_un; reg_rd && reg_addr != 4'h0 |=> reg_rdata == 8'h00; endproperty
   a_un: assert property (p_un) else $error("unmapped read not zero");
   property p_rsv; reg_rd |=> reg_rdata[5:4] == 2'h0; endproperty
   a_rsv: assert property (p_rsv) else $error("unused bits not zero");
   c_nd: cover property (noise_detect);
   c_un: cover property (reg_rd && reg_addr != 4'h0);
   c_osc: cover property (timer_src_sel == 2'h2);
endmodule // csc_chk
bind csc_control csc_chk csc_chk_inst (.sys_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
   .sense_module_on, .reference_mode_select, .osc_run, .noise_detect, .current_level, .timer_src_sel, .timer_ext_clk);

// *** tb/csc_control_tb_top.sv ***
`timescale 1ns/1ps
// drives the control register and checks the decoded outputs
module csc_control_tb_top;
   reg sys_clk = 1'h0, reset_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, dir = 1'h0, opt = 1'h0;
   reg [3:0] reg_addr = 4'h0;
   reg [7:0] reg_wdata = 8'h00;
   reg osc = 1'h0, pin = 1'h0;
   reg [7:0] exp_v = 8'h00;
   wire [7:0] reg_rdata;
   wire on, rm, run, nd, ext;
   wire [1:0] lvl, src;
   integer n_fail = 0, comparisons = 0, m, r;
   csc_control csc_control_inst (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .oscillator_direction_status(dir),
      .timer_clock_option(opt), .sense_osc_clk(osc), .timer_clock_pin(pin), .sense_module_on(on),
      .reference_mode_select(rm), .osc_run(run), .noise_detect(nd), .current_level(lvl),
      .timer_src_sel(src), .timer_ext_clk(ext));
   initial forever #10 sys_clk = ~sys_clk;
   task chk(input string n, input [7:0] s, input [7:0] e);
      comparisons = comparisons + 1;
      if (s !== e) begin
         n_fail = n_fail + 1;
         $display("[ERR] %s exp %h got %h", n, e, s);
      end
   endtask
   // strobes are one cycle; read data is looked at only in the cycle after
   task wr(input [3:0] a, input [7:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'h0;
   endtask
   task rd(input [3:0] a, input [7:0] e);
      @(posedge sys_clk);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'h0;
      #1 chk("rdata", reg_rdata, e);
   endtask
   task test_done;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // watchdog: the whole sequence needs only a few microseconds
   initial begin
      #50000;
      n_fail = n_fail + 1;
      test_done;
   end
   // every mode and range code; writes also set unused and status bits to see them dropped
   initial begin
      repeat (10) @(posedge sys_clk);
      reset_n <= 1'h1;
      rd(4'h0, 8'h00);
      for (m = 0; m < 2; m = m + 1) begin
         for (r = 0; r < 4; r = r + 1) begin
            @(posedge sys_clk);
            dir <= m[0];
            opt <= r[0];
            osc <= m[0];
            pin <= !m[0];
            wr(4'h0, {1'h1, m[0], 2'h3, r[1:0], 1'h1, r[1]});
            repeat (3) @(posedge sys_clk);
            exp_v = {1'h1, m[0], r != 0 || m[0], m[0] && r == 0, r[1:0], r[0] ? (r[1] ? 2'h2 : 2'h1) : 2'h0};
            #1 chk("outs", {on, rm, run, nd, lvl, src}, exp_v);
            exp_v = {7'h00, (r == 3) ? m[0] : ((r == 1) ? !m[0] : 1'h0)};
            chk("ext", {7'h00, ext}, exp_v);
            rd(4'h0, {1'h1, m[0], 2'h0, r[1:0], m[0], r[1]});
         end
      end
      $display("test modes done");
      @(posedge sys_clk);
      opt <= 1'h0;
      pin <= 1'h1;
      wr(4'h0, 8'h00);
      wr(4'h5, 8'hFF);
      repeat (3) @(posedge sys_clk);
      #1 chk("outs", {on, rm, run, nd, lvl, src}, 8'h00);
      chk("ext", {7'h00, ext}, 8'h00);
      $display("test disable done");
      rd(4'h5, 8'h00);
      rd(4'h0, 8'h02);
      $display("test unmapped done");
      test_done;
   end
endmodule // csc_control_tb_top
